//--- inc/pmvc_pkg.sv
// pmvc_pkg: shared constants and carrier types for the output-voltage command register bank
// assumes a same-clock protocol engine that decodes bus transactions into command requests
package pmvc_pkg;

  // command codes of the register bank
  localparam logic [7:0] CMD_FEATURE_REPORT = 8'h19;
  localparam logic [7:0] CMD_FORMAT_DESC    = 8'h20;
  localparam logic [7:0] CMD_SETPOINT       = 8'h21;
  localparam logic [7:0] CMD_CEILING        = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HIGH    = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW     = 8'h26;

  // bus feature report fields
  localparam int         FEAT_PEC_BIT       = 7;
  localparam int         FEAT_SPEED_LSB     = 5;
  localparam logic [1:0] FEAT_SPEED_400K    = 2'h1;
  localparam int         FEAT_ALERT_BIT     = 4;

  // output format descriptor fields
  localparam int         FMT_MODE_LSB       = 5;
  localparam logic [2:0] FMT_MODE_VID       = 3'h1;
  localparam logic [4:0] FMT_PARAM_NEWER    = 5'h02;
  localparam logic [4:0] FMT_PARAM_OLDER    = 5'h01;

  // reset values of the vid code registers
  localparam logic [7:0] CEILING_RESET      = 8'hff;
  localparam logic [7:0] MARGIN_RESET       = 8'h00;
  localparam logic [7:0] SETPOINT_PRELOAD   = 8'h00;

  // status bit positions driven by this bank
  localparam int         STB_OTHER_BIT      = 0;
  localparam int         STB_CML_BIT        = 1;
  localparam int         STW_VOUT_BIT       = 15;
  localparam int         STV_CEILING_BIT    = 3;
  localparam int         STC_BAD_DATA_BIT   = 6;

  // edges the pin synchroniser needs before the boot code is trusted
  localparam logic [1:0] BOOT_SETTLE_COUNT  = 2'h3;

  typedef enum logic [2:0] {
    PMVC_MODE_NOMINAL = 3'b001,
    PMVC_MODE_MARGIN_HIGH = 3'b010,
    PMVC_MODE_MARGIN_LOW = 3'b100
  } pmvc_mode_t;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } pmvc_cmd_t;

  typedef struct packed {
    logic        done;
    logic        refused;
    logic [15:0] data;
  } pmvc_rsp_t;

  typedef struct packed {
    logic [7:0]  status_byte;
    logic [15:0] status_word;
    logic [7:0]  status_vout;
    logic [7:0]  status_cml;
  } pmvc_status_t;

endpackage : pmvc_pkg

//--- hw/pmvc_vid_reg.sv
// pmvc_vid_reg: one 8-bit vid code register with a fixed reset value and a load strobe
// assumes load strobe and code come from logic on the same clock
`timescale 1ns/10ps
module pmvc_vid_reg #(
  parameter logic [7:0] RESET_CODE = 8'h00
) (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic       load_in,
  input  wire logic [7:0] load_code_in,
  output logic      [7:0] code_out
);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      code_out <= RESET_CODE;
    end else if (load_in) begin
      code_out <= load_code_in;
    end
  end

endmodule : pmvc_vid_reg

//--- hw/pmvc_vout_regs.sv
// pmvc_vout_regs: output-voltage command registers, clamp warning and alert of a buck controller
// assumes a same-clock protocol engine presenting one decoded command per request pulse,
// and asynchronous straps for the vid protocol select and the boot code
`timescale 1ns/10ps
// Functional notes
// - feature report bit 7 always reads one: packet error checking supported
// - feature report bits 6:5 always read 01: 400 kHz top bus speed
// - feature report bit 4 reads one: alert output and alert response present
// - format descriptor is one byte: mode 001 (vid) above a 5-bit parameter
// - parameter reads 00010 for newer vid protocol, 00001 for older
// - writes to format descriptor are refused, unchanged, flagged as invalid-data fault
// - vid registers take two bytes, right-justified code, bit zero in bit zero
// - vid codes decoded per protocol chosen by select pin or vendor config
// - setpoint low byte resets to boot code, never effective above ceiling; here it resets to 00 and loads the boot code three edges after reset release
// - a setpoint above ceiling is set to ceiling and counts as warning
// - clamp sets other, vout, ceiling-warning status bits and raises alert
// - ceiling holds max code in low byte, upper reserved, resets to 00ff
// - margin-high code, reset zero, becomes target in margin-high mode
module pmvc_vout_regs (
  input  wire logic                      clk_sys_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      cmd_valid_in,
  input  wire pmvc_pkg::pmvc_cmd_t       cmd_in,
  input  wire pmvc_pkg::pmvc_mode_t      op_mode_in,
  input  wire logic                      vid_protocol_select_pin_in,
  input  wire logic                      vendor_protocol_override_in,
  input  wire logic                      vendor_protocol_config_in,
  input  wire logic [7:0]                boot_voltage_in,
  input  wire logic                      status_clear_in,
  output pmvc_pkg::pmvc_rsp_t            rsp_out,
  output pmvc_pkg::pmvc_status_t         status_out,
  output logic                           alert_n_out,
  output logic [7:0]                     target_vid_out,
  output logic                           vid_protocol_newer_out,
  output logic                           boot_done_out
);

  // pin synchronisers: first stage is read only by the second
  logic       sel_pin_meta;
  logic       sel_pin_sync;
  logic [7:0] boot_meta;
  logic [7:0] boot_sync;

  // boot capture sequencing
  logic [1:0] boot_settle;
  logic       boot_load;

  // register contents
  logic [7:0] setpoint_code;
  logic [7:0] ceiling_code;
  logic [7:0] margin_high_code;
  logic [7:0] margin_low_code;

  // write decode
  logic       wr_req;
  logic       rd_req;
  logic       wr_setpoint;
  logic       wr_ceiling;
  logic       wr_margin_high;
  logic       wr_margin_low;
  logic       wr_readonly;
  logic       code_mapped;
  logic [7:0] wr_code;
  logic       clamp_hit;
  logic       protocol_newer;

  // load paths into the code registers
  logic       setpoint_load;
  logic [7:0] setpoint_next_code;

  // sticky status and the alert it drives
  logic       warn_other;
  logic       warn_vout;
  logic       warn_ceiling;
  logic       cml_flag;
  logic       cml_bad_data;
  logic       next_warn;
  logic       next_cml;

  // read mux
  logic [15:0] next_rdata;
  logic [7:0]  next_target;
  logic [7:0]  mode_code;
  logic [7:0]  feature_byte;
  logic [7:0]  format_byte;

  // select pin synchroniser: only the second stage feeds logic
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_pin_meta <= 1'b0;
      sel_pin_sync <= 1'b0;
    end else begin
      sel_pin_meta <= vid_protocol_select_pin_in;
      sel_pin_sync <= sel_pin_meta;
    end
  end

  // boot word crosses bit by bit: safe only because the strap holds still from reset release
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boot_meta <= 8'h00;
      boot_sync <= 8'h00;
    end else begin
      boot_meta <= boot_voltage_in;
      boot_sync <= boot_meta;
    end
  end

  // the boot code is a strap: wait for the synchroniser to fill before trusting it
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boot_settle <= 2'h0;
    end else if (boot_settle != pmvc_pkg::BOOT_SETTLE_COUNT) begin
      boot_settle <= boot_settle + 2'h1;
    end
  end

  // a setpoint write landing in the load cycle is lost to the boot code; hosts wait for boot_done
  assign boot_load = (boot_settle == (pmvc_pkg::BOOT_SETTLE_COUNT - 2'h1));

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boot_done_out <= 1'b0;
    end else if (boot_load) begin
      boot_done_out <= 1'b1;
    end
  end

  // vendor configuration outranks the pin, as it is set later by software
  assign protocol_newer = vendor_protocol_override_in ? vendor_protocol_config_in : sel_pin_sync;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vid_protocol_newer_out <= 1'b0;
    end else begin
      vid_protocol_newer_out <= protocol_newer;
    end
  end

  // command decode
  // only the low data byte is kept, so reserved upper bits can never be stored
  assign wr_req         = cmd_valid_in && cmd_in.write;
  assign rd_req         = cmd_valid_in && !cmd_in.write;
  assign wr_code        = cmd_in.data[7:0];
  assign wr_setpoint    = wr_req && (cmd_in.code == pmvc_pkg::CMD_SETPOINT);
  assign wr_ceiling     = wr_req && (cmd_in.code == pmvc_pkg::CMD_CEILING);
  assign wr_margin_high = wr_req && (cmd_in.code == pmvc_pkg::CMD_MARGIN_HIGH);
  assign wr_margin_low  = wr_req && (cmd_in.code == pmvc_pkg::CMD_MARGIN_LOW);
  assign wr_readonly    = wr_req && ((cmd_in.code == pmvc_pkg::CMD_FORMAT_DESC) ||
                                     (cmd_in.code == pmvc_pkg::CMD_FEATURE_REPORT));
  assign code_mapped    = (cmd_in.code == pmvc_pkg::CMD_FEATURE_REPORT) ||
                          (cmd_in.code == pmvc_pkg::CMD_FORMAT_DESC) ||
                          (cmd_in.code == pmvc_pkg::CMD_SETPOINT) ||
                          (cmd_in.code == pmvc_pkg::CMD_CEILING) ||
                          (cmd_in.code == pmvc_pkg::CMD_MARGIN_HIGH) ||
                          (cmd_in.code == pmvc_pkg::CMD_MARGIN_LOW);

  // a request above the ceiling is held at the ceiling rather than dropped
  assign clamp_hit = wr_setpoint && (wr_code > ceiling_code);

  always_comb begin
    setpoint_load      = 1'b0;
    setpoint_next_code = pmvc_pkg::SETPOINT_PRELOAD;
    if (boot_load) begin
      setpoint_load      = 1'b1;
      setpoint_next_code = boot_sync;
    end else if (clamp_hit) begin
      setpoint_load      = 1'b1;
      setpoint_next_code = ceiling_code;
    end else if (wr_setpoint) begin
      setpoint_load      = 1'b1;
      setpoint_next_code = wr_code;
    end
  end

  // setpoint starts at the preload and takes the boot code once the strap is synchronised
  pmvc_vid_reg #(
    .RESET_CODE   (pmvc_pkg::SETPOINT_PRELOAD)
  ) u_setpoint (
    .clk_sys_in   (clk_sys_in),
    .reset_n_in   (reset_n_in),
    .load_in      (setpoint_load),
    .load_code_in (setpoint_next_code),
    .code_out     (setpoint_code)
  );

  pmvc_vid_reg #(
    .RESET_CODE   (pmvc_pkg::CEILING_RESET)
  ) u_ceiling (
    .clk_sys_in   (clk_sys_in),
    .reset_n_in   (reset_n_in),
    .load_in      (wr_ceiling),
    .load_code_in (wr_code),
    .code_out     (ceiling_code)
  );

  pmvc_vid_reg #(
    .RESET_CODE   (pmvc_pkg::MARGIN_RESET)
  ) u_margin_high (
    .clk_sys_in   (clk_sys_in),
    .reset_n_in   (reset_n_in),
    .load_in      (wr_margin_high),
    .load_code_in (wr_code),
    .code_out     (margin_high_code)
  );

  pmvc_vid_reg #(
    .RESET_CODE   (pmvc_pkg::MARGIN_RESET)
  ) u_margin_low (
    .clk_sys_in   (clk_sys_in),
    .reset_n_in   (reset_n_in),
    .load_in      (wr_margin_low),
    .load_code_in (wr_code),
    .code_out     (margin_low_code)
  );

  // target selection; margin codes are not clamp-checked on write, so the cap below covers them
  always_comb begin
    case (op_mode_in)
      pmvc_pkg::PMVC_MODE_NOMINAL:     mode_code = setpoint_code;
      pmvc_pkg::PMVC_MODE_MARGIN_HIGH: mode_code = margin_high_code;
      pmvc_pkg::PMVC_MODE_MARGIN_LOW:  mode_code = margin_low_code;
      default:                         mode_code = setpoint_code;
    endcase
  end

  // the cap also bounds a later-lowered ceiling, which raises no warning
  always_comb begin
    next_target = mode_code;
    if (mode_code > ceiling_code) begin
      next_target = ceiling_code;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      target_vid_out <= pmvc_pkg::SETPOINT_PRELOAD;
    end else begin
      target_vid_out <= next_target;
    end
  end

  // sticky warning and fault flags: a new event wins over a clear in the same cycle
  assign next_warn = clamp_hit;
  assign next_cml  = wr_readonly;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      warn_other   <= 1'b0;
      warn_vout    <= 1'b0;
      warn_ceiling <= 1'b0;
    end else if (next_warn) begin
      warn_other   <= 1'b1;
      warn_vout    <= 1'b1;
      warn_ceiling <= 1'b1;
    end else if (status_clear_in) begin
      warn_other   <= 1'b0;
      warn_vout    <= 1'b0;
      warn_ceiling <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cml_flag <= 1'b0;
    end else if (next_cml) begin
      cml_flag <= 1'b1;
    end else if (status_clear_in) begin
      cml_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cml_bad_data <= 1'b0;
    end else if (next_cml) begin
      cml_bad_data <= 1'b1;
    end else if (status_clear_in) begin
      cml_bad_data <= 1'b0;
    end
  end

  // status is a registered copy so outputs come straight from flops
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_out <= '0;
    end else begin
      status_out <= '0;
      status_out.status_byte[pmvc_pkg::STB_OTHER_BIT]   <= warn_other || next_warn;
      status_out.status_byte[pmvc_pkg::STB_CML_BIT]     <= cml_flag || next_cml;
      status_out.status_word[pmvc_pkg::STW_VOUT_BIT]    <= warn_vout || next_warn;
      status_out.status_vout[pmvc_pkg::STV_CEILING_BIT] <= warn_ceiling || next_warn;
      status_out.status_cml[pmvc_pkg::STC_BAD_DATA_BIT] <= cml_bad_data || next_cml;
    end
  end

  // alert falls with any sticky source and only rises again through a clear
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alert_n_out <= 1'b1;
    end else begin
      alert_n_out <= !(warn_ceiling || next_warn || cml_bad_data || next_cml);
    end
  end

  // constant feature byte and protocol-dependent format byte
  always_comb begin
    feature_byte = 8'h00;
    feature_byte[pmvc_pkg::FEAT_PEC_BIT] = 1'b1;
    feature_byte[pmvc_pkg::FEAT_SPEED_LSB +: 2] = pmvc_pkg::FEAT_SPEED_400K;
    feature_byte[pmvc_pkg::FEAT_ALERT_BIT] = 1'b1;
    format_byte = {pmvc_pkg::FMT_MODE_VID,
                   (protocol_newer ? pmvc_pkg::FMT_PARAM_NEWER : pmvc_pkg::FMT_PARAM_OLDER)};
  end

  // read data: upper byte of every vid register is reserved zero
  always_comb begin
    next_rdata = 16'h0000;
    case (cmd_in.code)
      pmvc_pkg::CMD_FEATURE_REPORT: next_rdata = {8'h00, feature_byte};
      pmvc_pkg::CMD_FORMAT_DESC:    next_rdata = {8'h00, format_byte};
      pmvc_pkg::CMD_SETPOINT:       next_rdata = {8'h00, setpoint_code};
      pmvc_pkg::CMD_CEILING:        next_rdata = {8'h00, ceiling_code};
      pmvc_pkg::CMD_MARGIN_HIGH:    next_rdata = {8'h00, margin_high_code};
      pmvc_pkg::CMD_MARGIN_LOW:     next_rdata = {8'h00, margin_low_code};
      default:                      next_rdata = 16'h0000;
    endcase
  end

  // one answer per request, one cycle later; unmapped and read-only writes are refused
  // data is zeroed for writes and refusals so no stale register byte leaks out
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rsp_out <= '0;
    end else begin
      rsp_out.done    <= cmd_valid_in;
      rsp_out.refused <= cmd_valid_in && (!code_mapped || wr_readonly);
      rsp_out.data    <= (rd_req && code_mapped) ? next_rdata : 16'h0000;
    end
  end

endmodule : pmvc_vout_regs

//--- verification/pmvc_vout_regs_props.sv
// pmvc_vout_regs_props: assertions on the command port, status flags and target of the bank
// assumes one clock domain and an answer exactly one edge after each request
`timescale 1ns/10ps
module pmvc_vout_regs_props (
  input wire logic                   clk_sys_in,
  input wire logic                   reset_n_in,
  input wire logic                   cmd_valid_in,
  input wire pmvc_pkg::pmvc_cmd_t    cmd_in,
  input wire logic                   status_clear_in,
  input wire pmvc_pkg::pmvc_rsp_t    rsp_out,
  input wire pmvc_pkg::pmvc_status_t status_out,
  input wire logic                   alert_n_out,
  input wire logic [7:0]             target_vid_out,
  input wire logic                   vid_protocol_newer_out,
  input wire logic                   boot_done_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  logic [7:0]  ceil_q;
  logic [23:0] ceil_h;
  // shadow of the ceiling; history kept since the target follows a new ceiling late
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) ceil_q <= 8'hff;
    else if (cmd_valid_in && cmd_in.write && cmd_in.code == 8'h24) ceil_q <= cmd_in.data[7:0];
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) ceil_h <= 24'hffffff;
    else ceil_h <= {ceil_h[15:0], ceil_q};
  end
  sequence s_rd(c); cmd_valid_in && !cmd_in.write && cmd_in.code == c; endsequence
  sequence s_wr(c); cmd_valid_in && cmd_in.write && cmd_in.code == c; endsequence
  sequence s_quiet; status_clear_in && !cmd_valid_in ##1 !cmd_valid_in [*2]; endsequence
  property p_done; cmd_valid_in |=> rsp_out.done && rsp_out.data[15:8] == 8'h00; endproperty
  property p_idle; !cmd_valid_in |=> !rsp_out.done; endproperty
  property p_feat; s_rd(8'h19) |=> rsp_out.data == 16'h00b0 && !rsp_out.refused; endproperty
  property p_fmt;
    s_rd(8'h20) |=> rsp_out.data == {8'h00, 3'h1, vid_protocol_newer_out ? 5'h02 : 5'h01};
  endproperty
  property p_ro;
    s_wr(8'h20) |=> rsp_out.refused && status_out.status_cml[6] && status_out.status_byte[1] && !alert_n_out;
  endproperty
  property p_unmap;
    cmd_valid_in && !(cmd_in.code inside {8'h19, 8'h20, 8'h21, 8'h24, 8'h25, 8'h26})
      |=> rsp_out.refused && rsp_out.data == 16'h0000;
  endproperty
  property p_clamp;
    cmd_valid_in && cmd_in.write && cmd_in.code == 8'h21 && cmd_in.data[7:0] > ceil_q |=> status_out.status_byte[0]
      && status_out.status_word[15] && status_out.status_vout[3] && !alert_n_out;
  endproperty
  property p_cap;
    boot_done_out |-> target_vid_out <= ceil_h[7:0] || target_vid_out <= ceil_h[15:8]
      || target_vid_out <= ceil_h[23:16];
  endproperty
  property p_quiet; s_quiet |=> alert_n_out && status_out == '0; endproperty
  a_done: assert property (p_done) else $error("answer missing or upper byte set");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_feat: assert property (p_feat) else $error("feature report wrong");
  a_fmt: assert property (p_fmt) else $error("format descriptor wrong");
  a_ro: assert property (p_ro) else $error("descriptor write not refused");
  a_unmap: assert property (p_unmap) else $error("unmapped code not refused");
  a_clamp: assert property (p_clamp) else $error("clamp warning missing");
  a_cap: assert property (p_cap) else $error("target above ceiling");
  a_quiet: assert property (p_quiet) else $error("status not cleared");
endmodule : pmvc_vout_regs_props
bind pmvc_vout_regs pmvc_vout_regs_props u_props (.clk_sys_in, .reset_n_in, .cmd_valid_in, .cmd_in,
  .status_clear_in, .rsp_out, .status_out, .alert_n_out, .target_vid_out, .vid_protocol_newer_out,
  .boot_done_out);

//--- verification/pmvc_host_model.sv
// pmvc_host_model: command requester standing in for the bus protocol engine
// assumes the bank answers each request one edge later, so no wait is needed here
`timescale 1ns/10ps
module pmvc_host_model (
  input  wire logic           clk_sys_in,
  output logic                cmd_valid_out,
  output pmvc_pkg::pmvc_cmd_t cmd_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end
  // fields are inverted between pulses so sampling outside the strobe shows up
  task automatic req(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(negedge clk_sys_in);
    cmd_valid_out = 1'b1;
    cmd_out = '{write: wr, code: code, data: data};
    @(negedge clk_sys_in);
    cmd_valid_out = 1'b0;
    cmd_out = ~cmd_out;
  endtask : req
endmodule : pmvc_host_model

//--- verification/tb_top.sv
// tb_top: self-checking bench of the output-voltage command register bank
// assumes the host model drives the command port; straps and modes driven here
`timescale 1ns/10ps
module tb_top;
  logic                   clk_sys_in, reset_n_in, cmd_valid, pin, ovr, cfg, clr, alert_n, newer, boot_done;
  pmvc_pkg::pmvc_cmd_t    cmd;
  pmvc_pkg::pmvc_mode_t   mode;
  pmvc_pkg::pmvc_rsp_t    rsp;
  pmvc_pkg::pmvc_status_t st;
  logic [7:0]             boot, target, v;
  logic [16:0]            exp_q[$];
  int                     err_count = 0;
  int                     checks_done = 0;
  int                     seed = 32'h7a53;
  logic [7:0]  codes [7] = '{8'h19, 8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h30};
  logic [16:0] vals [7] = '{17'h000b0, 17'h00022, 17'h00040, 17'h000ff, 17'h0, 17'h0, 17'h10000};
  pmvc_host_model u_host (.clk_sys_in(clk_sys_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd));
  pmvc_vout_regs u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .op_mode_in(mode), .vid_protocol_select_pin_in(pin), .vendor_protocol_override_in(ovr),
    .vendor_protocol_config_in(cfg), .boot_voltage_in(boot), .status_clear_in(clr), .rsp_out(rsp),
    .status_out(st), .alert_n_out(alert_n), .target_vid_out(target), .vid_protocol_newer_out(newer),
    .boot_done_out(boot_done));
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [63:0] seen, input logic [63:0] expv, input string what);
    checks_done++;
    if (seen !== expv) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask : chk
  task automatic op(input logic wr, input logic [7:0] c, input logic [15:0] d, input logic [16:0] x);
    exp_q.push_back(x);
    u_host.req(wr, c, d);
  endtask : op
  // bounded wait for every noted answer, then two edges so registered levels settle
  task automatic drain;
    for (int i = 0; i < 8 && exp_q.size() > 0; i++) @(negedge clk_sys_in);
    if (exp_q.size() != 0) begin
      err_count++;
      final_report;
    end
    repeat (2) @(negedge clk_sys_in);
  endtask : drain
  task automatic clear_status;
    clr = 1'b1;
    @(negedge clk_sys_in);
    clr = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    chk({alert_n, st}, {1'b1, 40'h0}, "cleared status");
  endtask : clear_status
  always @(negedge clk_sys_in) begin
    if (reset_n_in && rsp.done === 1'b1) begin
      if (exp_q.size() == 0) chk(1, 0, "spare answer");
      else chk({rsp.refused, rsp.data}, exp_q.pop_front(), "answer");
    end
  end
  initial begin
    {reset_n_in, ovr, cfg, clr} = 4'h0;
    pin = 1'b1;
    boot = 8'h40;
    mode = pmvc_pkg::PMVC_MODE_NOMINAL;
    repeat (20) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    for (int i = 0; i < 20 && boot_done !== 1'b1; i++) @(negedge clk_sys_in);
    if (boot_done !== 1'b1) begin
      err_count++;
      final_report;
    end
    repeat (2) @(negedge clk_sys_in);
    chk(target, 8'h40, "boot target");
    chk(newer, 1'b1, "protocol from pin");
    for (int i = 0; i < 7; i++) op(1'b0, codes[i], 16'($random(seed)), vals[i]);
    drain;
    $display("test reset values done");
    op(1'b1, 8'h20, 16'h00ff, 17'h10000);
    op(1'b1, 8'h19, 16'h0000, 17'h10000);
    op(1'b0, 8'h20, 16'h0000, 17'h00022);
    drain;
    chk({st.status_cml[6], st.status_byte[1], alert_n}, 3'b110, "invalid data flags");
    clear_status;
    $display("test read-only refusal done");
    op(1'b1, 8'h24, 16'hab80, 17'h0);
    op(1'b0, 8'h24, 16'h0000, 17'h00080);
    op(1'b1, 8'h21, 16'h55c0, 17'h0);
    op(1'b0, 8'h21, 16'h0000, 17'h00080);
    drain;
    chk({st.status_byte[0], st.status_word[15], st.status_vout[3], alert_n}, 4'b1110, "clamp flags");
    chk(target, 8'h80, "clamped target");
    clear_status;
    op(1'b1, 8'h21, 16'h0070, 17'h0);
    drain;
    chk({alert_n, target}, 9'h170, "target below ceiling");
    $display("test ceiling clamp done");
    for (int m = 0; m < 2; m++) begin
      v = 8'($random(seed)) & 8'h7f;
      op(1'b1, 8'h25 + 8'(m), {8'($random(seed)), v}, 17'h0);
      op(1'b0, 8'h25 + 8'(m), 16'h0000, {9'h000, v});
      mode = m ? pmvc_pkg::PMVC_MODE_MARGIN_LOW : pmvc_pkg::PMVC_MODE_MARGIN_HIGH;
      drain;
      chk(target, v, "margin target");
    end
    mode = pmvc_pkg::PMVC_MODE_NOMINAL;
    $display("test margins done");
    ovr = 1'b1;
    op(1'b0, 8'h20, 16'h0000, 17'h00021);
    drain;
    chk(newer, 1'b0, "protocol from vendor config");
    {ovr, cfg, pin} = 3'b010;
    repeat (4) @(negedge clk_sys_in);
    op(1'b0, 8'h20, 16'h0000, 17'h00021);
    drain;
    chk(newer, 1'b0, "protocol from pin");
    $display("test protocol select done");
    final_report;
  end
endmodule : tb_top
